// File: rfg_defines.vh
// constants for the receive frame buffer overwrite guard
`ifndef RFG_DEFINES_VH
`define RFG_DEFINES_VH
// ===========================================
// register map
`define RFG_ADDR_XCVR_CTRL_TWO 6'h0C
`define RFG_BIT_GUARD_EN 7
`define RFG_BIT_SCRAM_EN 5
`define RFG_RST_XCVR_CTRL_TWO 8'h20
`define RFG_MASK_XCVR_CTRL_TWO 8'hA7
// ===========================================
// spi command byte encodings
`define RFG_CMD_REG_RD 2'b10
`define RFG_CMD_REG_WR 2'b11
`define RFG_CMD_FB_RD 3'b001
`define RFG_CMD_FB_WR 3'b011
`define RFG_CMD_SRAM_RD 3'b000
`define RFG_CMD_SRAM_WR 3'b010
// ===========================================
// transceiver state codes that count as listening
`define RFG_STATE_PLAIN_LISTEN 5'h06
`define RFG_STATE_AUTO_ACK_LISTEN 5'h16
`endif

// File: rfg_frame_mem.v
// frame buffer storage: one write port, one registered read port
`timescale 1ns/1ps
module rfg_frame_mem #(
  parameter AW = 7,
  parameter DW = 8
) (
  input wire i_mclk,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire i_re,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);
  // ===========================================
  // storage array, no reset: content is undefined until written
  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  // write port
  always @(posedge i_mclk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // registered read, one cycle latency
  always @(posedge i_mclk) begin
    if (i_re) begin
      o_rdata <= mem_q[i_raddr];
    end
  end
endmodule

// File: rfg_guard.v
// frame buffer with spi access and dynamic overwrite guard
`timescale 1ns/1ps
`include "rfg_defines.vh"
// Summary of operation
// [R1] listening keeps receiving; new frame replaces old
// [R2] guard armed blocks air frames until read ends
// [R3] basic mode arms only on valid fcs
// [R4] extended mode arms only on frame-end interrupt
// [R5] guard needs enable bit, listen states only
// [R6] spi writes still modify the buffer
// [R7] release on select rise after a buffer read, or leaving listen
// [R8] host raises select to end buffer read
// [R9] threshold setting has no effect on guard
// [R10] enable bit resets to zero, writable
// [R11] scrambler bit five, rate bits, reserved zero
// [R12] internal protected flag, set end, clear release
module rfg_guard #(
  parameter AW = 7
) (
  input wire i_mclk,
  input wire i_reset,
  // spi pins from the host
  input wire i_sclk,
  input wire i_sel_n,
  input wire i_mosi,
  output wire o_miso,
  // radio receive byte stream
  input wire i_rx_valid,
  input wire i_rx_sof,
  input wire [7:0] i_rx_data,
  output wire o_rx_ready,
  // radio frame end and its qualifiers
  input wire i_rx_end,
  input wire i_rx_fcs_ok,
  input wire i_frame_end_interrupt,
  input wire i_extended_mode,
  input wire [4:0] i_trx_state,
  // control outputs
  output wire o_scrambler_enable,
  output wire [2:0] o_phy_data_rate_select,
  output wire o_protected
);
  // ===========================================
  // command kinds held during one select frame
  localparam K_NONE = 3'd0;
  localparam K_REG_RD = 3'd1;
  localparam K_REG_WR = 3'd2;
  localparam K_FB_RD = 3'd3;
  localparam K_FB_WR = 3'd4;
  localparam K_SRAM_RD = 3'd5;
  localparam K_SRAM_WR = 3'd6;

  // ===========================================
  // pin synchronisers; first stage is read by second stage only
  reg [2:0] sclk_s_q; // [0] first stage, [2] edge history
  reg [2:0] sel_s_q;
  reg [1:0] mosi_s_q;
  // select resets high, its idle level, so no false edge follows reset
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sclk_s_q <= 3'h0;
      sel_s_q <= 3'h7;
      mosi_s_q <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], i_sclk};
      sel_s_q <= {sel_s_q[1:0], i_sel_n};
      mosi_s_q <= {mosi_s_q[0], i_mosi};
    end
  end
  // edges come from the settled stage against one cycle of history
  wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  wire sel_active = ~sel_s_q[1];
  wire sel_fall = ~sel_s_q[1] & sel_s_q[2];
  wire sel_rise = sel_s_q[1] & ~sel_s_q[2];

  // ===========================================
  // control register
  reg guard_en_q; // overwrite guard enable
  reg scram_en_q; // scrambler enable
  reg [2:0] rate_q; // phy data rate select
  // reserved bits 6, 4, 3 read as zero
  wire [7:0] ctrl_rd = {guard_en_q, 1'b0, scram_en_q, 2'b00, rate_q}; // [R11]

  // ===========================================
  // spi byte engine
  reg [2:0] bitcnt_q; // bits received in current byte
  reg [7:0] sh_q; // receive shifter
  reg [7:0] tx_q; // transmit shifter, msb drives miso
  reg first_q; // next byte is the command
  reg addr_ph_q; // next byte is an sram address
  reg [2:0] kind_q; // current command kind
  reg [5:0] reg_addr_q; // register address
  reg [AW-1:0] ptr_q; // frame buffer / sram pointer
  reg rd_req_q; // memory read issued last cycle, data ready now
  wire byte_done = sel_active & sclk_rise & (bitcnt_q == 3'd7);
  wire [7:0] rx_byte = {sh_q[6:0], mosi_s_q[1]};
  wire [7:0] mem_rdata;
  reg spi_we; // spi write into buffer this cycle
  reg rd_issue; // start a memory read for the next out byte

  // decode write and read strobes from the finished byte
  always @* begin
    spi_we = 1'b0;
    rd_issue = 1'b0;
    if (byte_done) begin
      if (first_q) begin
        // command byte: a buffer read fetches address zero at once
        rd_issue = (rx_byte[7:5] == `RFG_CMD_FB_RD);
      end else if (addr_ph_q) begin
        rd_issue = (kind_q == K_SRAM_RD);
      end else begin
        // spi writes land regardless of the guard
        spi_we = (kind_q == K_FB_WR) | (kind_q == K_SRAM_WR); // [R6]
        rd_issue = (kind_q == K_FB_RD) | (kind_q == K_SRAM_RD);
      end
    end
  end

  // spi sequencing: command decode, pointer, transmit shifter
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      bitcnt_q <= 3'd0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      first_q <= 1'b1;
      addr_ph_q <= 1'b0;
      kind_q <= K_NONE;
      reg_addr_q <= 6'h00;
      ptr_q <= {AW{1'b0}};
      rd_req_q <= 1'b0;
      guard_en_q <= 1'b0; // [R10]
      scram_en_q <= 1'b1; // [R11]
      rate_q <= 3'd0;
    end else begin
      rd_req_q <= rd_issue;
      if (!sel_active || sel_fall) begin
        // idle or new access: restart byte framing
        bitcnt_q <= 3'd0;
        first_q <= 1'b1;
        addr_ph_q <= 1'b0;
        tx_q <= 8'h00;
        if (!sel_active) begin
          kind_q <= K_NONE;
        end
      end else begin
        if (sclk_rise) begin
          bitcnt_q <= bitcnt_q + 3'd1;
          sh_q <= rx_byte;
        end
        // shift out on falling edges inside a byte only
        if (sclk_fall && bitcnt_q != 3'd0) begin
          tx_q <= {tx_q[6:0], 1'b0};
        end
        if (rd_req_q) begin
          // read data arrive before the next falling edge
          tx_q <= mem_rdata;
          ptr_q <= ptr_q + {{(AW-1){1'b0}}, 1'b1};
        end
        // a whole byte is in: command, address or data
        if (byte_done) begin
          if (first_q) begin
            // command byte fixes the kind for the rest of the access
            first_q <= 1'b0;
            reg_addr_q <= rx_byte[5:0];
            if (rx_byte[7:6] == `RFG_CMD_REG_RD) begin
              // reply goes out in the next byte; unmapped addresses give zero
              kind_q <= K_REG_RD;
              tx_q <= (rx_byte[5:0] == `RFG_ADDR_XCVR_CTRL_TWO) ? ctrl_rd : 8'h00;
            end else if (rx_byte[7:6] == `RFG_CMD_REG_WR) begin
              kind_q <= K_REG_WR;
            end else begin
              // buffer and sram commands restart the pointer at zero
              case (rx_byte[7:5])
                `RFG_CMD_FB_RD: kind_q <= K_FB_RD;
                `RFG_CMD_FB_WR: kind_q <= K_FB_WR;
                `RFG_CMD_SRAM_RD: kind_q <= K_SRAM_RD;
                `RFG_CMD_SRAM_WR: kind_q <= K_SRAM_WR;
                default: kind_q <= K_NONE;
              endcase
              ptr_q <= {AW{1'b0}};
              addr_ph_q <= rx_byte[6:5] == 2'b00 || rx_byte[6:5] == 2'b10;
            end
          end else if (addr_ph_q) begin
            // sram address byte sets the pointer
            addr_ph_q <= 1'b0;
            ptr_q <= rx_byte[AW-1:0];
          end else if (kind_q == K_REG_WR) begin
            // only the control register is mapped; others ignore writes
            if (reg_addr_q == `RFG_ADDR_XCVR_CTRL_TWO) begin
              guard_en_q <= rx_byte[`RFG_BIT_GUARD_EN]; // [R10]
              scram_en_q <= rx_byte[`RFG_BIT_SCRAM_EN]; // [R11]
              rate_q <= rx_byte[2:0]; // [R11]
            end
          end else if (spi_we) begin
            // data byte stored, step to the next address
            ptr_q <= ptr_q + {{(AW-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  end
  assign o_miso = tx_q[7];

  // ===========================================
  // two-entry buffer between radio stream and the memory
  reg [8:0] buf_q [0:1]; // {sof, data}
  reg buf_wp_q;
  reg buf_rp_q;
  reg [1:0] buf_cnt_q;
  wire buf_full = (buf_cnt_q == 2'd2);
  wire buf_vld = (buf_cnt_q != 2'd0);
  wire buf_push = i_rx_valid & ~buf_full;
  // spi writes own the write port, the drain stalls behind them
  wire buf_pop = buf_vld & ~spi_we;
  wire [8:0] buf_head = buf_q[buf_rp_q];
  assign o_rx_ready = ~buf_full;

  // ring of two slots; count moves by push minus pop
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      buf_q[0] <= 9'h000;
      buf_q[1] <= 9'h000;
      buf_wp_q <= 1'b0;
      buf_rp_q <= 1'b0;
      buf_cnt_q <= 2'd0;
    end else begin
      // a byte is taken whenever a slot is free
      if (buf_push) begin
        buf_q[buf_wp_q] <= {i_rx_sof, i_rx_data};
        buf_wp_q <= ~buf_wp_q;
      end
      if (buf_pop) begin
        buf_rp_q <= ~buf_rp_q;
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // ===========================================
  // overwrite guard
  wire in_listen = (i_trx_state == `RFG_STATE_PLAIN_LISTEN) ||
                   (i_trx_state == `RFG_STATE_AUTO_ACK_LISTEN); // [R5]
  reg listen_q; // listen state one cycle ago
  reg prot_q; // protected flag
  reg drop_q; // current air frame is being discarded
  reg [AW-1:0] rx_ptr_q; // air write pointer
  // no threshold input exists here, so the guard cannot depend on it [R9]
  wire frame_ok = i_extended_mode ? i_frame_end_interrupt : i_rx_fcs_ok; // [R3] [R4]
  // arming is judged at the end pulse; bytes still queued are kept
  wire arm = guard_en_q & in_listen & i_rx_end & frame_ok; // [R5] [R12]
  // limitation: a frame dropped whole still arms on its good end pulse
  // release: select rises after a frame buffer read, or listen is left
  wire release_fb = sel_rise & (kind_q == K_FB_RD); // [R7] [R8]
  wire release_st = listen_q & ~in_listen; // [R7]
  wire guard_on = prot_q & guard_en_q & in_listen; // [R5]
  // a frame's fate is fixed at its first byte so it is never torn
  wire drop_now = (buf_head[8] ? guard_on : drop_q);
  wire air_we = buf_pop & ~drop_now; // [R1] [R2]
  wire [AW-1:0] air_addr = buf_head[8] ? {AW{1'b0}} : rx_ptr_q; // [R1]

  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      listen_q <= 1'b0;
      prot_q <= 1'b0; // [R12]
      drop_q <= 1'b0;
      rx_ptr_q <= {AW{1'b0}};
    end else begin
      // listen one cycle ago reveals a step out of it
      listen_q <= in_listen;
      // setting wins over a release in the same cycle
      if (arm) begin
        prot_q <= 1'b1; // [R12]
      end else if (release_fb || release_st || !guard_en_q) begin
        prot_q <= 1'b0; // [R7] [R10]
      end
      // pointer follows the drain; a start byte restarts it at zero
      if (buf_pop) begin
        drop_q <= drop_now; // [R2]
        rx_ptr_q <= air_addr + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ===========================================
  // frame buffer storage
  // spi writes win the shared write port; the radio drain waits for them
  // read address: zero for the buffer command, the address byte for sram
  rfg_frame_mem #(
    .AW(AW),
    .DW(8)
  ) u_mem (
    .i_mclk(i_mclk),
    .i_we(spi_we | air_we),
    .i_waddr(spi_we ? ptr_q : air_addr),
    .i_wdata(spi_we ? rx_byte : buf_head[7:0]),
    .i_re(rd_issue),
    .i_raddr(first_q ? {AW{1'b0}} : (addr_ph_q ? rx_byte[AW-1:0] : ptr_q)),
    .o_rdata(mem_rdata)
  );

  // control bits and the flag leave straight from their registers
  assign o_scrambler_enable = scram_en_q;
  assign o_phy_data_rate_select = rate_q;
  assign o_protected = prot_q;
endmodule

// File: rfg_guard_asserts.sv
// port checker for the frame buffer overwrite guard
`timescale 1ns/1ps
`include "rfg_defines.vh"
module rfg_guard_asserts #(
  parameter AW = 7
) (
  input wire i_mclk,
  input wire i_reset,
  input wire i_sel_n,
  input wire o_miso,
  input wire o_rx_ready,
  input wire i_rx_end,
  input wire i_rx_fcs_ok,
  input wire i_frame_end_interrupt,
  input wire i_extended_mode,
  input wire [4:0] i_trx_state,
  input wire o_scrambler_enable,
  input wire [2:0] o_phy_data_rate_select,
  input wire o_protected
);
  // =====================================
  // listen decode
  wire lsn = (i_trx_state == `RFG_STATE_PLAIN_LISTEN) ||
             (i_trx_state == `RFG_STATE_AUTO_ACK_LISTEN);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // =====================================
  // arming causes
  arm_needs_end_a: assert property ($rose(o_protected) |-> $past(i_rx_end))
    else $error("protected rose without frame end");
  basic_fcs_arm_a: assert property (
    $rose(o_protected) && !$past(i_extended_mode) |-> $past(i_rx_fcs_ok))
    else $error("basic arm without good fcs");
  ext_int_arm_a: assert property (
    $rose(o_protected) && $past(i_extended_mode) |-> $past(i_frame_end_interrupt))
    else $error("extended arm without frame end interrupt");
  listen_arm_a: assert property ($rose(o_protected) |-> $past(lsn))
    else $error("armed outside listen");
  // =====================================
  // release and hold; select needs two sync flops, hence five idle cycles
  leave_listen_a: assert property (!lsn |=> !o_protected)
    else $error("flag kept outside listen");
  hold_idle_a: assert property (i_sel_n [*5] ##0 (o_protected && lsn) |=> o_protected)
    else $error("flag dropped with host idle");
  ctrl_idle_a: assert property (
    i_sel_n [*5] |=> $stable(o_scrambler_enable) && $stable(o_phy_data_rate_select))
    else $error("control bits moved without access");
  miso_idle_a: assert property (i_sel_n [*5] |-> !o_miso)
    else $error("miso driven while deselected");
  reset_vals_a: assert property (
    $fell(i_reset) |-> !o_protected && o_scrambler_enable &&
    o_phy_data_rate_select == 3'h0 && o_rx_ready)
    else $error("bad values after reset");
  cover property ($rose(o_protected));
  cover property ($fell(o_protected) && lsn);
  cover property (!o_rx_ready);
endmodule

bind rfg_guard rfg_guard_asserts #(.AW(AW)) chk_u (.i_mclk, .i_reset, .i_sel_n, .o_miso,
  .o_rx_ready, .i_rx_end, .i_rx_fcs_ok, .i_frame_end_interrupt, .i_extended_mode, .i_trx_state,
  .o_scrambler_enable, .o_phy_data_rate_select, .o_protected);

// File: rfg_host_model.sv
// spi host model reading and writing the guarded frame buffer
`timescale 1ns/1ps
module rfg_host_model (
  input wire i_mclk,
  input wire i_miso,
  output reg o_sclk,
  output reg o_sel_n,
  output reg o_mosi
);
  // idle: deselected, clock parked low
  initial begin
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
    o_mosi = 1'b0;
  end
  // mode 0 access, sclk at mclk/10 to stay under the sync limit
  task xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    o_sel_n <= 1'b0;
    repeat (5) @(posedge i_mclk);
    for (int i = 0; i < 8 * n; i++) begin
      o_mosi <= tx[31 - i];
      repeat (5) @(posedge i_mclk);
      rx = {rx[30:0], i_miso};
      o_sclk <= 1'b1;
      repeat (5) @(posedge i_mclk);
      o_sclk <= 1'b0;
    end
    repeat (5) @(posedge i_mclk);
    o_sel_n <= 1'b1;
    o_mosi <= ~o_mosi; // released line never keeps a stale level
    repeat (10) @(posedge i_mclk);
  endtask
endmodule

// File: tb_rx_frame_buffer_overwrite_guard.sv
// self-checking bench for the frame buffer overwrite guard
`timescale 1ns/1ps
module tb_rx_frame_buffer_overwrite_guard;
  reg i_mclk = 1'b0, i_reset = 1'b1, i_rx_valid = 1'b0, i_rx_sof = 1'b0, i_rx_end = 1'b0;
  reg i_rx_fcs_ok = 1'b0, i_frame_end_interrupt = 1'b0, i_extended_mode = 1'b0;
  reg [7:0] i_rx_data = 8'h00;
  reg [4:0] i_trx_state = 5'h06;
  wire i_sclk, i_sel_n, i_mosi, o_miso, o_rx_ready, o_scrambler_enable, o_protected;
  wire [2:0] o_phy_data_rate_select;
  logic [31:0] r;
  int fails = 0, num_checks = 0;
  always #2 i_mclk = ~i_mclk;
  rfg_guard dut_u (.i_mclk, .i_reset, .i_sclk, .i_sel_n, .i_mosi, .o_miso, .i_rx_valid,
    .i_rx_sof, .i_rx_data, .o_rx_ready, .i_rx_end, .i_rx_fcs_ok, .i_frame_end_interrupt,
    .i_extended_mode, .i_trx_state, .o_scrambler_enable, .o_phy_data_rate_select, .o_protected);
  rfg_host_model host_u (.i_mclk(i_mclk), .i_miso(o_miso), .o_sclk(i_sclk), .o_sel_n(i_sel_n),
    .o_mosi(i_mosi));
  // =====================================
  // compares: data values and single flags
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chkf(input logic exp);
    num_checks++;
    if (o_protected !== exp) begin
      fails++;
      $display("wrong value protected expected %b seen %b", exp, o_protected);
    end
  endtask
  // =====================================
  // register and buffer access over spi
  task wr(input logic [5:0] a, input logic [7:0] d);
    host_u.xfer(2, {2'b11, a, d, 16'h0000}, r);
  endtask
  task rd(input logic [5:0] a, input logic [7:0] exp);
    host_u.xfer(2, {2'b10, a, 24'h000000}, r);
    chk("register", {16'h0000, exp}, {16'h0000, r[7:0]});
  endtask
  task fbrd(input logic [23:0] exp);
    host_u.xfer(4, 32'h20000000, r);
    chk("buffer", exp, r[23:0]);
  endtask
  // three-byte frame from the air, then its end pulse
  task frame(input logic [23:0] d, input logic fcs, input logic fei);
    for (int i = 0; i < 3; i++) begin
      i_rx_valid <= 1'b1;
      i_rx_sof <= (i == 0);
      i_rx_data <= d[23 - 8 * i -: 8];
      // ready is judged settled at the falling edge, the byte goes at the next rise
      @(negedge i_mclk);
      while (o_rx_ready !== 1'b1) @(negedge i_mclk);
      @(posedge i_mclk);
    end
    i_rx_valid <= 1'b0;
    i_rx_end <= 1'b1;
    i_rx_fcs_ok <= fcs;
    i_frame_end_interrupt <= fei;
    @(posedge i_mclk);
    i_rx_end <= 1'b0;
    repeat (6) @(posedge i_mclk);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the sequence needs about 11 us
  initial begin
    #100000;
    fails++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    rd(6'h0C, 8'h20);
    wr(6'h0C, 8'hFF);
    rd(6'h0C, 8'hA7);
    wr(6'h0C, 8'h23);
    wr(6'h0D, 8'h55);
    rd(6'h0D, 8'h00);
    chk("rate", 24'h00000B, {20'h0, o_scrambler_enable, o_phy_data_rate_select});
    $display("test registers done");
    frame(24'h111213, 1'b1, 1'b0);
    frame(24'h212223, 1'b1, 1'b0);
    chkf(1'b0);
    fbrd(24'h212223);
    $display("test overwrite done");
    wr(6'h0C, 8'hA3);
    frame(24'h313233, 1'b0, 1'b0);
    chkf(1'b0);
    frame(24'h414243, 1'b1, 1'b0);
    chkf(1'b1);
    frame(24'h515253, 1'b1, 1'b0);
    fbrd(24'h414243);
    chkf(1'b0);
    frame(24'h616263, 1'b1, 1'b0);
    chkf(1'b1);
    host_u.xfer(2, 32'h60770000, r);
    fbrd(24'h776263);
    $display("test basic guard done");
    i_extended_mode <= 1'b1;
    i_trx_state <= 5'h16;
    frame(24'h717273, 1'b1, 1'b0);
    chkf(1'b0);
    frame(24'h818283, 1'b0, 1'b1);
    chkf(1'b1);
    i_trx_state <= 5'h08;
    repeat (3) @(posedge i_mclk);
    chkf(1'b0);
    frame(24'h919293, 1'b1, 1'b1);
    chkf(1'b0);
    i_trx_state <= 5'h16;
    frame(24'hA1A2A3, 1'b0, 1'b1);
    chkf(1'b1);
    wr(6'h0C, 8'h00);
    chkf(1'b0);
    $display("test extended guard done");
    end_sim;
  end
endmodule
